// ===== src/tcs_pkg.sv
// Shared constants for the tape command and sense logic
package tcs_pkg;
  // Command codes on the five command lines
  localparam logic [4:0] CMD_FILE_SEARCH_REV = 5'h0b;
  localparam logic [4:0] CMD_SELECT_PHASE = 5'h13;
  localparam logic [4:0] CMD_SELECT_GROUP = 5'h1b;
  localparam logic [4:0] CMD_READ_SENSE = 5'h19;
  localparam logic [4:0] CMD_DIAGNOSE = 5'h0c;
  // Diagnostic first and second byte values
  localparam logic [7:0] DIAG_FULL = 8'h01;
  localparam logic [7:0] DIAG_LOADED = 8'h02;
  localparam logic [7:0] DIAG_NO_OPTION = 8'h00;
  // Reject codes
  localparam logic [5:0] REJ_NONE = 6'h00;
  localparam logic [5:0] REJ_NOT_READY = 6'h01;
  localparam logic [5:0] REJ_FILE_PROTECT = 6'h05;
  localparam logic [5:0] REJ_NO_ERASE = 6'h06;
  localparam logic [5:0] REJ_SEQUENCE = 6'h07;
  localparam logic [5:0] REJ_NO_READ = 6'h08;
  localparam logic [5:0] REJ_ID_BURST = 6'h09;
  localparam logic [5:0] REJ_NO_WRITE = 6'h0c;
  localparam logic [5:0] REJ_NOISE = 6'h0f;
  localparam logic [5:0] REJ_WRITE_OVERRUN = 6'h10;
  localparam logic [5:0] REJ_READY_LOST = 6'h11;
  // Sense transfer
  localparam int SENSE_BYTES = 8;
  localparam int DIAG_BYTES = 2;
  // Strobe timing
  localparam int CLK_MHZ = 50;
  localparam int STROBE_WIDTH_NS = 400;
  localparam int DATA_SETUP_NS = 300;
  localparam int STROBE_CYCLES = (STROBE_WIDTH_NS * CLK_MHZ) / 1000;
  localparam int SETUP_CYCLES = (DATA_SETUP_NS * CLK_MHZ + 999) / 1000;
  localparam int CNT_W = 8;
endpackage

// ===== src/tcs_sense_shift.sv
// Sense byte sender: byte on the read bus, then one strobe pulse per byte
`timescale 1ns/1ns
module tcs_sense_shift #(
  parameter int NBYTES = tcs_pkg::SENSE_BYTES
) (
  input wire logic mclk_in, // System clock
  input wire logic reset_n_in, // Asynchronous reset, active low
  input wire logic start_in, // One-cycle start pulse
  input wire logic [8*NBYTES-1:0] snap_in, // Byte 0 in the top lane
  output logic [7:0] data_out, // Read data, bit 7 = line zero
  output logic parity_out, // Odd parity
  output logic strobe_out, // Read strobe pulse
  output logic busy_out // Sequence in progress
);
  typedef enum logic [3:0] {
    TCS_IDLE = 4'b0001,
    TCS_SETUP = 4'b0010,
    TCS_PULSE = 4'b0100,
    TCS_GAP = 4'b1000
  } tcs_shift_state_t;

  tcs_shift_state_t state_reg;
  logic [tcs_pkg::CNT_W-1:0] cnt_reg;
  logic [3:0] idx_reg;
  logic [8*NBYTES-1:0] snap_reg;

  assign busy_out = (state_reg != TCS_IDLE);

  ////////////////////////////////////////////////////////////////////////////
  // Snapshot held for the whole transfer
  always_ff @(posedge mclk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
      snap_reg <= '0;
    else if (start_in && state_reg == TCS_IDLE)
      snap_reg <= snap_in;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer
  always_ff @(posedge mclk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      state_reg <= TCS_IDLE;
      cnt_reg <= '0;
      idx_reg <= '0;
      data_out <= 8'h00;
      parity_out <= 1'b1;
      strobe_out <= 1'b0;
    end
    else
    begin
      case (state_reg)
        TCS_IDLE:
        begin
          strobe_out <= 1'b0;
          idx_reg <= '0;
          if (start_in)
          begin
            data_out <= snap_in[8*NBYTES-1 -: 8];
            parity_out <= ~^snap_in[8*NBYTES-1 -: 8];
            cnt_reg <= tcs_pkg::CNT_W'(tcs_pkg::SETUP_CYCLES - 1);
            state_reg <= TCS_SETUP;
          end
        end
        TCS_SETUP:
        begin
          if (cnt_reg == '0)
          begin
            strobe_out <= 1'b1;
            cnt_reg <= tcs_pkg::CNT_W'(tcs_pkg::STROBE_CYCLES - 1);
            state_reg <= TCS_PULSE;
          end
          else
            cnt_reg <= cnt_reg - 1'b1;
        end
        TCS_PULSE:
        begin
          if (cnt_reg == '0)
          begin
            strobe_out <= 1'b0;
            cnt_reg <= tcs_pkg::CNT_W'(tcs_pkg::STROBE_CYCLES - 1);
            state_reg <= TCS_GAP;
          end
          else
            cnt_reg <= cnt_reg - 1'b1;
        end
        TCS_GAP:
        begin
          if (cnt_reg != '0)
            cnt_reg <= cnt_reg - 1'b1;
          else if (idx_reg == 4'(NBYTES - 1))
            state_reg <= TCS_IDLE;
          else
          begin
            idx_reg <= idx_reg + 1'b1;
            data_out <= snap_reg[8*NBYTES-9 - 8*idx_reg -: 8];
            parity_out <= ~^snap_reg[8*NBYTES-9 - 8*idx_reg -: 8];
            cnt_reg <= tcs_pkg::CNT_W'(tcs_pkg::SETUP_CYCLES - 1);
            state_reg <= TCS_SETUP;
          end
        end
        default:
          state_reg <= TCS_IDLE;
      endcase
    end
  end
endmodule

// ===== src/tcs_sync.sv
// Two flip-flop synchroniser for asynchronous inputs
`timescale 1ns/1ns
module tcs_sync #(
  parameter int WIDTH = 1
) (
  input wire logic mclk_in, // System clock
  input wire logic reset_n_in, // Asynchronous reset, active low
  input wire logic [WIDTH-1:0] async_in, // Unsynchronised input
  output logic [WIDTH-1:0] sync_out // Synchronised output
);
  logic [WIDTH-1:0] meta_reg;

  always_ff @(posedge mclk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      meta_reg <= '0;
      sync_out <= '0;
    end
    else
    begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end
endmodule

// ===== src/tcs_top.sv
// Tape command decode and sense reporting logic
// What this block does
// - Code 01011 searches backward over blocks until a tape mark, no data.
// - Code 10011 selects phase-encoded mode; busy drops; needs unloaded or at BEGINNING_OF_TAPE.
// - Code 11011 selects group-coded mode; busy drops; needs unloaded or at BEGINNING_OF_TAPE.
// - Code 11001 returns exactly eight sense bytes.
// - Each byte is placed on the bus, then the read strobe pulses once.
// - Sense bit 0 is the MSB and drives read data line zero.
// - Odd parity accompanies every sense byte.
// - Byte 1 echoes the last command bits 7 down to 0.
// - Byte 2 carries the eight tape status flags.
// - Byte 3 carries hard errors; bit 4 reads zero.
// - Byte 4 carries BEGINNING_OF_TAPE reached, errors, reject, incomplete, overrun; bit 3 zero.
// - Byte 5 holds diagnostic flag, a zero, then six-bit reject code.
// - Byte 6 bits 0-2 flag corrected reads; one is set when corrected error set.
// - Byte 6 bits 3,4 show gap selection; 5,6 zero; 7 dead parity track.
// - Byte 7 bit n flags dead data track n.
// - Diagnose 01100 takes two write bytes; both busy lines held throughout.
// - First byte 01 full package (unloads), 02 loaded; second byte 00.
// - Reject 1 not ready, 5 write under file protect, 7 illegal sequence.
// - Reject 6 no erase status, 8 no read status, C no write status.
// - Reject 9 ID burst, F noise, 10 overrun at END_OF_TAPE, 11 ready lost.
// - Host presents each write byte after its strobe; no acknowledgement sent.
`timescale 1ns/1ns
module tcs_top #(
  parameter int DIAG_CYCLES = 1000,
  parameter int SEARCH_CYCLES = 100
) (
  input wire logic mclk_in, // 50 MHz clock
  input wire logic reset_n_in, // Asynchronous reset, active low
  input wire logic go_in, // Command start pin
  input wire logic [4:0] command_code_lines_in, // Command code pins
  input wire logic [7:0] cmd_mod_bits_in, // Command modifier bits 7..0
  input wire logic [7:0] write_data_in, // Host write data pins
  input wire logic loaded_in, // Drive loaded
  input wire logic ready_in, // Drive ready
  input wire logic [7:0] tape_status_in, // Byte 2 flags, bit 7 = flag 0
  input wire logic [7:0] hard_err_a_in, // Byte 3 flags
  input wire logic [7:0] hard_err_b_in, // Byte 4 flags
  input wire logic [2:0] corrected_in, // Corrected read kinds, bit 2 = flag 0
  input wire logic [1:0] gap_sel_in, // Gap select: bit 1 +0.3, bit 0 +0.6
  input wire logic dead_parity_in, // Dead parity track
  input wire logic [7:0] dead_track_in, // Dead track n on bit n
  input wire logic tape_mark_in, // Tape mark block seen
  input wire logic [5:0] fault_code_in, // Reject code from motion logic
  input wire logic fault_in, // Motion logic fault event
  output logic formatter_busy_line_out, // Formatter busy
  output logic transfer_busy_line_out, // Data busy
  output logic write_demand_strobe_out, // Write data demand strobe
  output logic [7:0] read_data_out, // Read data, [7] is line zero
  output logic read_parity_out, // Odd parity line
  output logic read_strobe_pulse_out, // Read strobe
  output logic corrected_error_line_out, // Corrected error
  output logic phase_encoded_mode_out, // Mode: 1 PE, 0 GROUP_CODED_MODE
  output logic reverse_search_out, // Backward search motion
  output logic unload_out, // Unload request pulse
  output logic diag_loaded_out // Loaded diagnostic run
);
  typedef enum logic [5:0] {
    TCS_IDLE = 6'b000001,
    TCS_SEARCH = 6'b000010,
    TCS_SENSE = 6'b000100,
    TCS_DIAG_XFER = 6'b001000,
    TCS_DIAG_RUN = 6'b010000,
    TCS_DONE = 6'b100000
  } tcs_state_t;

  function automatic logic [5:0] tcs_mode_check(input logic ld, input logic beginning_of_tape);
    tcs_mode_check = (!ld || beginning_of_tape) ? tcs_pkg::REJ_NONE : tcs_pkg::REJ_SEQUENCE;
  endfunction

  tcs_state_t state_reg;
  logic go_s, go_d_reg, mark_s, ready_s, loaded_s, go_rise;
  logic [4:0] cmd_s;
  logic [7:0] mod_s, wdata_s;
  logic [7:0] last_cmd_reg;
  logic [5:0] reject_reg;
  logic diag_mode_reg;
  logic [15:0] cnt_reg;
  logic [1:0] byte_cnt_reg;
  logic [7:0] diag_sel_reg;
  logic shift_start, shift_busy;
  logic [63:0] snapshot;

  ////////////////////////////////////////////////////////////////////////////
  // Synchronisers
  tcs_sync #(.WIDTH(25)) u_sync (
    .mclk_in(mclk_in),
    .reset_n_in(reset_n_in),
    .async_in({go_in, command_code_lines_in, cmd_mod_bits_in, write_data_in,
      tape_mark_in, ready_in, loaded_in}),
    .sync_out({go_s, cmd_s, mod_s, wdata_s, mark_s, ready_s, loaded_s})
  );

  always_ff @(posedge mclk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
      go_d_reg <= 1'b0;
    else
      go_d_reg <= go_s;
  end
  assign go_rise = go_s && !go_d_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Sense image, byte 0 in the top lane; bit 7 of each byte is sense bit 0
  assign snapshot = {
    {3'b000, !ready_s, 4'h0},
    last_cmd_reg,
    tape_status_in,
    hard_err_a_in[7:4], 1'b0, hard_err_a_in[2:0],
    hard_err_b_in[7:5], 1'b0, hard_err_b_in[3:0],
    diag_mode_reg, 1'b0, reject_reg,
    corrected_in, gap_sel_in, 2'b00, dead_parity_in,
    {dead_track_in[0], dead_track_in[1], dead_track_in[2], dead_track_in[3],
     dead_track_in[4], dead_track_in[5], dead_track_in[6], dead_track_in[7]}
  };
  assign corrected_error_line_out = |corrected_in;

  tcs_sense_shift #(.NBYTES(tcs_pkg::SENSE_BYTES)) u_shift (
    .mclk_in(mclk_in),
    .reset_n_in(reset_n_in),
    .start_in(shift_start),
    .snap_in(snapshot),
    .data_out(read_data_out),
    .parity_out(read_parity_out),
    .strobe_out(read_strobe_pulse_out),
    .busy_out(shift_busy)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Command state machine
  always_ff @(posedge mclk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      state_reg <= TCS_IDLE;
      last_cmd_reg <= 8'h00;
      reject_reg <= tcs_pkg::REJ_NONE;
      diag_mode_reg <= 1'b0;
      phase_encoded_mode_out <= 1'b1;
      cnt_reg <= '0;
      byte_cnt_reg <= '0;
      diag_sel_reg <= 8'h00;
      shift_start <= 1'b0;
      formatter_busy_line_out <= 1'b0;
      transfer_busy_line_out <= 1'b0;
      write_demand_strobe_out <= 1'b0;
      reverse_search_out <= 1'b0;
      unload_out <= 1'b0;
      diag_loaded_out <= 1'b0;
    end
    else
    begin
      shift_start <= 1'b0;
      unload_out <= 1'b0;
      write_demand_strobe_out <= 1'b0;
      if (fault_in)
        reject_reg <= fault_code_in;
      case (state_reg)
        TCS_IDLE:
        begin
          formatter_busy_line_out <= 1'b0;
          transfer_busy_line_out <= 1'b0;
          if (go_rise)
          begin
            formatter_busy_line_out <= 1'b1;
            if (cmd_s != tcs_pkg::CMD_READ_SENSE)
              last_cmd_reg <= mod_s;
            state_reg <= TCS_DONE;
            if (cmd_s == tcs_pkg::CMD_READ_SENSE)
            begin
              shift_start <= 1'b1;
              state_reg <= TCS_SENSE;
            end
            else if (cmd_s == tcs_pkg::CMD_SELECT_PHASE
              || cmd_s == tcs_pkg::CMD_SELECT_GROUP)
            begin
              reject_reg <= tcs_mode_check(loaded_s, tape_status_in[1]);
              if (tcs_mode_check(loaded_s, tape_status_in[1]) == tcs_pkg::REJ_NONE)
                phase_encoded_mode_out <= (cmd_s == tcs_pkg::CMD_SELECT_PHASE);
            end
            else if (!ready_s)
              reject_reg <= tcs_pkg::REJ_NOT_READY;
            else if (mod_s[2] && tape_status_in[4])
              reject_reg <= tcs_pkg::REJ_FILE_PROTECT;
            else if (cmd_s == tcs_pkg::CMD_FILE_SEARCH_REV)
            begin
              reverse_search_out <= 1'b1;
              cnt_reg <= 16'(SEARCH_CYCLES);
              state_reg <= TCS_SEARCH;
            end
            else if (cmd_s == tcs_pkg::CMD_DIAGNOSE)
            begin
              transfer_busy_line_out <= 1'b1;
              byte_cnt_reg <= '0;
              cnt_reg <= '0;
              state_reg <= TCS_DIAG_XFER;
            end
            else
              reject_reg <= tcs_pkg::REJ_SEQUENCE;
          end
        end
        TCS_SEARCH:
        begin
          // Each clock cycle is counted down; tape mark or timeout stops in the gap
          if (mark_s || cnt_reg == '0)
          begin
            reverse_search_out <= 1'b0;
            state_reg <= TCS_DONE;
          end
          else
            cnt_reg <= cnt_reg - 1'b1;
        end
        TCS_SENSE:
        begin
          if (!shift_start && !shift_busy)
            state_reg <= TCS_DONE;
        end
        TCS_DIAG_XFER:
        begin
          // Demand strobe every 32 cycles; data sampled before the next strobe
          cnt_reg <= cnt_reg + 1'b1;
          if (cnt_reg[4:0] == 5'h01)
            write_demand_strobe_out <= 1'b1;
          if (cnt_reg[4:0] == 5'h1f)
          begin
            byte_cnt_reg <= byte_cnt_reg + 1'b1;
            if (byte_cnt_reg == 2'd0)
              diag_sel_reg <= wdata_s;
            else
            begin
              cnt_reg <= 16'(DIAG_CYCLES);
              if ((diag_sel_reg == tcs_pkg::DIAG_FULL
                || diag_sel_reg == tcs_pkg::DIAG_LOADED)
                && wdata_s == tcs_pkg::DIAG_NO_OPTION)
              begin
                diag_mode_reg <= 1'b1;
                diag_loaded_out <= (diag_sel_reg == tcs_pkg::DIAG_LOADED);
                unload_out <= (diag_sel_reg == tcs_pkg::DIAG_FULL);
                state_reg <= TCS_DIAG_RUN;
              end
              else
              begin
                reject_reg <= tcs_pkg::REJ_SEQUENCE;
                state_reg <= TCS_DONE;
              end
            end
          end
        end
        TCS_DIAG_RUN:
        begin
          if (cnt_reg == '0)
          begin
            diag_mode_reg <= 1'b0;
            diag_loaded_out <= 1'b0;
            state_reg <= TCS_DONE;
          end
          else
            cnt_reg <= cnt_reg - 1'b1;
        end
        TCS_DONE:
        begin
          formatter_busy_line_out <= 1'b0;
          transfer_busy_line_out <= 1'b0;
          if (!go_s)
            state_reg <= TCS_IDLE;
        end
        default:
          state_reg <= TCS_IDLE;
      endcase
    end
  end
endmodule

// ===== tb/tcs_host_model.sv
// Host controller model: issues commands, feeds write bytes, collects sense bytes
`timescale 1ns/1ns
module tcs_host_model (
  input wire logic mclk_in, // Clock
  input wire logic busy_in, // Formatter busy
  input wire logic demand_in, // Write demand strobe
  input wire logic [7:0] rdata_in, // Read data
  input wire logic rpar_in, // Read parity
  input wire logic strobe_in, // Read strobe
  output logic go_out, // Command start
  output logic [4:0] code_out, // Command code
  output logic [7:0] mod_out, // Modifier bits
  output logic [7:0] wdata_out // Write data
);
  logic [7:0] b1;
  logic [7:0] b2;
  logic [1:0] dcnt;
  logic strobe_d;
  logic [8:0] got [$];
  initial
  begin
    go_out = 1'b0;
    code_out = 5'h00;
    mod_out = 8'h00;
    wdata_out = 8'hff;
    dcnt = 2'h0;
    strobe_d = 1'b0;
  end
  ////////////////////////////////////////////////////////////
  // Sample each sense byte on its strobe; present write bytes after each demand
  always @(posedge mclk_in)
  begin
    strobe_d <= strobe_in;
    if (strobe_in && !strobe_d)
      got.push_back({rpar_in, rdata_in});
    if (demand_in)
    begin
      dcnt <= dcnt + 2'h1;
      wdata_out <= (dcnt == 2'h0) ? b1 : b2;
    end
    else if (!busy_in)
    begin
      dcnt <= 2'h0;
      wdata_out <= ~wdata_out;
    end
  end
  // Code and modifiers settle two cycles before go rises
  task automatic issue(input logic [4:0] c, input logic [7:0] m, x, y);
    @(posedge mclk_in);
    code_out <= c;
    mod_out <= m;
    b1 <= x;
    b2 <= y;
    got.delete();
    repeat (2) @(posedge mclk_in);
    go_out <= 1'b1;
  endtask
  task automatic release_go;
    @(posedge mclk_in);
    go_out <= 1'b0;
  endtask
endmodule

// ===== tb/tcs_top_assertions.sv
// Port-level checker for the tape command and sense logic
`timescale 1ns/1ns
module tcs_top_assertions (
  input wire logic mclk_in, // Clock
  input wire logic reset_n_in, // Reset, active low
  input wire logic [2:0] corrected_in, // Corrected read kinds
  input wire logic formatter_busy_line_out, // Formatter busy
  input wire logic transfer_busy_line_out, // Data busy
  input wire logic write_demand_strobe_out, // Write demand
  input wire logic [7:0] read_data_out, // Read data
  input wire logic read_parity_out, // Odd parity
  input wire logic read_strobe_pulse_out, // Read strobe
  input wire logic corrected_error_line_out, // Corrected error
  input wire logic phase_encoded_mode_out, // Mode
  input wire logic reverse_search_out, // Backward search
  input wire logic unload_out // Unload pulse
);
  logic [7:0] str_cnt;
  logic [1:0] dem_cnt;
  default clocking cb @(posedge mclk_in);
  endclocking
  default disable iff (!reset_n_in);
  ////////////////////////////////////////////////////////////
  // Cycles the read strobe has stood high
  always_ff @(posedge mclk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
      str_cnt <= 8'h00;
    else if (read_strobe_pulse_out)
      str_cnt <= str_cnt + 8'h01;
    else
      str_cnt <= 8'h00;
  end
  // Demand strobes seen within one data busy period
  always_ff @(posedge mclk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
      dem_cnt <= 2'h0;
    else if (!transfer_busy_line_out)
      dem_cnt <= 2'h0;
    else if (write_demand_strobe_out)
      dem_cnt <= dem_cnt + 2'h1;
  end
  sequence strobe_rest;
    !read_strobe_pulse_out [*8];
  endsequence
  sequence demand_end;
    ##1 !write_demand_strobe_out;
  endsequence
  ////////////////////////////////////////////////////////////
  strobe_width_a: assert property ($fell(read_strobe_pulse_out) |-> str_cnt == 8'h14)
    else $error("read strobe width wrong");
  strobe_gap_a: assert property ($fell(read_strobe_pulse_out) |-> strobe_rest)
    else $error("read strobes too close");
  data_setup_a: assert property ($rose(read_strobe_pulse_out) |->
    read_data_out == $past(read_data_out, 14)) else $error("read data set too late");
  data_hold_a: assert property (read_strobe_pulse_out |->
    $stable(read_data_out) && $stable(read_parity_out)) else $error("read data moved");
  parity_odd_a: assert property (read_strobe_pulse_out |-> ^{read_data_out, read_parity_out})
    else $error("parity not odd");
  strobe_busy_a: assert property (read_strobe_pulse_out |-> formatter_busy_line_out)
    else $error("strobe outside command");
  corrected_line_a: assert property (corrected_error_line_out == (|corrected_in))
    else $error("corrected error line wrong");
  busy_nest_a: assert property (transfer_busy_line_out |-> formatter_busy_line_out)
    else $error("data busy without formatter busy");
  demand_count_a: assert property ($fell(transfer_busy_line_out) |-> dem_cnt == 2'h2)
    else $error("write transfer not two bytes");
  demand_pulse_a: assert property (write_demand_strobe_out |->
    transfer_busy_line_out ##0 demand_end) else $error("demand strobe wrong");
  unload_pulse_a: assert property (unload_out |-> formatter_busy_line_out ##1 !unload_out)
    else $error("unload pulse wrong");
  mode_change_a: assert property ($changed(phase_encoded_mode_out) |->
    formatter_busy_line_out || $past(formatter_busy_line_out)) else $error("mode moved idle");
  search_quiet_a: assert property (reverse_search_out |->
    formatter_busy_line_out && !read_strobe_pulse_out) else $error("search moved data");
endmodule
bind tcs_top tcs_top_assertions chk (.mclk_in, .reset_n_in, .corrected_in,
  .formatter_busy_line_out, .transfer_busy_line_out, .write_demand_strobe_out, .read_data_out,
  .read_parity_out, .read_strobe_pulse_out, .corrected_error_line_out, .phase_encoded_mode_out,
  .reverse_search_out, .unload_out);

// ===== tb/tcs_top_bench.sv
// Self-checking bench for the tape command and sense logic
`timescale 1ns/1ns
module tcs_top_bench;
  logic mclk_in = 1'b0;
  logic reset_n_in = 1'b0;
  logic go;
  logic [4:0] code;
  logic [7:0] mods;
  logic [7:0] wdata;
  logic loaded = 1'b0;
  logic ready = 1'b1;
  logic mark = 1'b0;
  logic fault = 1'b0;
  logic dpar = 1'b1;
  logic [7:0] tstat = 8'hc9;
  logic [7:0] dtrack = 8'h1d;
  logic [5:0] fcode = 6'h00;
  logic [2:0] corr = 3'h5;
  logic fbusy, tbusy, wds, rpar, rstr, cerr, pe, rev, unl, dload;
  logic [7:0] rdata;
  logic [7:0] sb [8];
  logic [5:0] codes [7] = '{6'h06, 6'h08, 6'h0c, 6'h09, 6'h0f, 6'h10, 6'h11};
  logic seen_unl = 1'b0;
  logic seen_dl = 1'b0;
  int errors = 0;
  int comparisons = 0;
  always #10 mclk_in = ~mclk_in;
  tcs_top #(.DIAG_CYCLES(50), .SEARCH_CYCLES(40)) dut (.mclk_in(mclk_in),
    .reset_n_in(reset_n_in), .go_in(go), .command_code_lines_in(code), .cmd_mod_bits_in(mods),
    .write_data_in(wdata), .loaded_in(loaded), .ready_in(ready), .tape_status_in(tstat),
    .hard_err_a_in(8'h5e), .hard_err_b_in(8'hb3), .corrected_in(corr), .gap_sel_in(2'h2),
    .dead_parity_in(dpar), .dead_track_in(dtrack), .tape_mark_in(mark), .fault_code_in(fcode),
    .fault_in(fault), .formatter_busy_line_out(fbusy), .transfer_busy_line_out(tbusy),
    .write_demand_strobe_out(wds), .read_data_out(rdata), .read_parity_out(rpar),
    .read_strobe_pulse_out(rstr), .corrected_error_line_out(cerr),
    .phase_encoded_mode_out(pe), .reverse_search_out(rev), .unload_out(unl),
    .diag_loaded_out(dload));
  tcs_host_model host (.mclk_in(mclk_in), .busy_in(fbusy), .demand_in(wds), .rdata_in(rdata),
    .rpar_in(rpar), .strobe_in(rstr), .go_out(go), .code_out(code), .mod_out(mods),
    .wdata_out(wdata));
  always @(posedge mclk_in)
  begin
    if (unl)
      seen_unl <= 1'b1;
    if (dload)
      seen_dl <= 1'b1;
  end
  ////////////////////////////////////////////////////////////
  task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
    comparisons++;
    if (got !== exp)
    begin
      errors++;
      $display("BAD %0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic summarize;
    $display("errors %0d comparisons %0d", errors, comparisons);
    if (errors == 0 && comparisons > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic await(input logic want, input int limit);
    for (int i = 0; i < limit && fbusy !== want; i++)
      @(posedge mclk_in);
    if (fbusy !== want)
    begin
      errors++;
      $display("BAD %0t busy wait ran out", $time);
      summarize();
    end
  endtask
  task automatic run(input logic [4:0] c, input logic [7:0] m, x, y, input int limit);
    host.issue(c, m, x, y);
    await(1'b1, 50);
    host.release_go();
    await(1'b0, limit);
  endtask
  task automatic sense;
    run(tcs_pkg::CMD_READ_SENSE, 8'h6a, 8'h00, 8'h00, 1000);
    check(8'(host.got.size()), 8'h08, "sense byte count");
    for (int i = 0; i < 8; i++)
    begin
      sb[i] = host.got[i][7:0];
      check({7'h00, ^host.got[i]}, 8'h01, "sense parity");
    end
  endtask
  ////////////////////////////////////////////////////////////
  initial
  begin
    repeat (8) @(posedge mclk_in);
    reset_n_in <= 1'b1;
    repeat (4) @(posedge mclk_in);
    run(tcs_pkg::CMD_SELECT_GROUP, 8'h6a, 8'h00, 8'h00, 50);
    check({7'h00, pe}, 8'h00, "group mode");
    run(tcs_pkg::CMD_SELECT_PHASE, 8'h6a, 8'h00, 8'h00, 50);
    check({7'h00, pe}, 8'h01, "phase mode");
    loaded <= 1'b1;
    run(tcs_pkg::CMD_SELECT_GROUP, 8'h6a, 8'h00, 8'h00, 50);
    check({7'h00, pe}, 8'h01, "mode kept off start of tape");
    $display("test mode select done");
    fork
    begin
      repeat (150) @(posedge mclk_in);
      dtrack <= 8'h00;
    end
    join_none
    sense();
    dtrack <= 8'h1d;
    check(sb[0], 8'h00, "byte 0");
    check(sb[1], 8'h6a, "command echo");
    check(sb[2], 8'hc9, "tape status");
    check(sb[3], 8'h56, "hard errors a");
    check(sb[4], 8'ha3, "hard errors b");
    check(sb[5], 8'h07, "sequence reject");
    check(sb[6], 8'hb1, "corrected and gap");
    check(sb[7], 8'hb8, "dead tracks");
    check({7'h00, cerr}, 8'h01, "corrected line set");
    $display("test sense layout done");
    tstat <= 8'hcb;
    corr <= 3'h0;
    run(tcs_pkg::CMD_SELECT_GROUP, 8'h6a, 8'h00, 8'h00, 50);
    tstat <= 8'hc9;
    check({7'h00, pe}, 8'h00, "mode at start of tape");
    check({7'h00, cerr}, 8'h00, "corrected line clear");
    ready <= 1'b0;
    run(tcs_pkg::CMD_FILE_SEARCH_REV, 8'h00, 8'h00, 8'h00, 50);
    ready <= 1'b1;
    sense();
    check(sb[5], 8'h01, "not ready reject");
    check(sb[6], 8'h11, "no corrected read");
    tstat <= 8'hd9;
    run(tcs_pkg::CMD_FILE_SEARCH_REV, 8'h04, 8'h00, 8'h00, 50);
    tstat <= 8'hc9;
    sense();
    check(sb[5], 8'h05, "file protect reject");
    foreach (codes[i])
    begin
      fcode <= codes[i];
      fault <= 1'b1;
      @(posedge mclk_in);
      fault <= 1'b0;
      sense();
      check(sb[5], {2'h0, codes[i]}, "motion reject");
    end
    $display("test reject codes done");
    fork
    begin
      repeat (14) @(posedge mclk_in);
      check({7'h00, rev}, 8'h01, "searching backward");
      mark <= 1'b1;
    end
    join_none
    run(tcs_pkg::CMD_FILE_SEARCH_REV, 8'h00, 8'h00, 8'h00, 80);
    mark <= 1'b0;
    check({7'h00, rev}, 8'h00, "search halted");
    check(8'(host.got.size()), 8'h00, "search moved no data");
    $display("test reverse search done");
    run(tcs_pkg::CMD_DIAGNOSE, 8'h00, tcs_pkg::DIAG_FULL, tcs_pkg::DIAG_NO_OPTION, 400);
    check({7'h00, seen_unl}, 8'h01, "full package unloads");
    run(tcs_pkg::CMD_DIAGNOSE, 8'h00, tcs_pkg::DIAG_LOADED, tcs_pkg::DIAG_NO_OPTION, 400);
    check({7'h00, seen_dl}, 8'h01, "loaded package runs");
    run(tcs_pkg::CMD_DIAGNOSE, 8'h00, tcs_pkg::DIAG_LOADED, 8'h05, 400);
    sense();
    check(sb[5] & 8'h3f, 8'h07, "reserved option");
    $display("test diagnostics done");
    summarize();
  end
endmodule
